// [fpc_regs_top.sv]
// Protection, status, function and read-parameter registers of the flash
`timescale 1ns/1ps
module fpc_regs_top #(
	parameter int ADDR_W = 24
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              sck_in,
	input  wire logic              ce_n_in,
	input  wire logic              io0_in,
	output logic                   io1_out,
	output logic                   io1_oe_out,
	input  wire logic              io2_in,
	input  wire logic              io3_in,
	input  wire logic              quad_command_mode_in,
	input  wire logic              busy_in,
	input  wire logic              array_done_in,
	input  wire logic              suspend_in,
	input  wire logic              resume_in,
	input  wire logic              prog_active_in,
	input  wire logic              erase_active_in,
	input  wire logic [7:0]        read_opcode_in,
	input  wire logic [ADDR_W-1:0] rd_addr_in,
	output logic                   hold_active_out,
	output logic                   io23_data_mode_out,
	output logic [3:0]             dummy_cycles_out,
	output logic [2:0]             drive_strength_out,
	output logic                   wrap_enable_out,
	output logic [6:0]             burst_bytes_out,
	output logic [ADDR_W-1:0]      rd_next_addr_out,
	output logic                   array_start_out,
	output logic                   array_inhibit_out,
	output logic [7:0]             array_opcode_out,
	output logic [ADDR_W-1:0]      array_addr_out,
	output logic [3:0]             info_row_lock_out
);
	typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA, ST_DONE} fpc_state_t;

	fpc_link_if link ();

	fpc_state_t        state_q;
	logic [7:0]        op_q;
	logic [ADDR_W-1:0] addr_q;
	logic [1:0]        addr_cnt_q;
	logic [7:0]        data_q;
	logic              have_data_q;
	logic [7:2]        sr_q;
	logic              wel_q;
	logic [7:0]        fr_q;
	logic [7:0]        rp_q;
	logic [1:0]        wp_s_q;
	logic [1:0]        hold_s_q;
	logic [3:0]        lvl;
	logic              sr_unlocked;
	logic              write_ok;
	logic              is_array_op;
	logic              is_chip_erase;
	logic              blk_hit;
	logic [7:0]        status;
	logic [ADDR_W-1:0] wrap_mask;
	logic [ADDR_W-1:0] addr_inc;

	fpc_spi_link u_link (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.sck_in     (sck_in),
		.ce_n_in    (ce_n_in),
		.si_in      (io0_in),
		.so_out     (io1_out),
		.so_oe_out  (io1_oe_out),
		.link       (link.shifter)
	);

	// ****************************************
	// Pin function and write protection
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wp_s_q   <= 2'h3;
			hold_s_q <= 2'h3;
		end else begin
			wp_s_q   <= {wp_s_q[0], io2_in};
			hold_s_q <= {hold_s_q[0], io3_in};
		end
	end

	// In quad mode the pins carry data, so they lose their control role
	assign io23_data_mode_out = sr_q[fpc_pkg::SR_QE_BIT];
	assign hold_active_out = ~sr_q[fpc_pkg::SR_QE_BIT] & ~hold_s_q[1];
	assign sr_unlocked = ~sr_q[fpc_pkg::SR_LOCK_BIT] | wp_s_q[1] |
		sr_q[fpc_pkg::SR_QE_BIT];

	assign lvl = sr_q[fpc_pkg::SR_LVL_LSB +: 4];
	assign status = {sr_q, wel_q, busy_in};
	assign write_ok = link.frame_end & wel_q & ~busy_in;

	// ****************************************
	// Instruction sequencing
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q     <= ST_CMD;
			op_q        <= 8'h00;
			addr_q      <= '0;
			addr_cnt_q  <= 2'h0;
			data_q      <= 8'h00;
			have_data_q <= 1'b0;
		end else if (link.frame_start) begin
			state_q     <= ST_CMD;
			op_q        <= 8'h00;
			addr_cnt_q  <= 2'h0;
			have_data_q <= 1'b0;
		end else if (link.byte_valid) begin
			unique case (state_q)
				ST_CMD: begin
					op_q <= link.rx_byte;
					if (link.rx_byte == fpc_pkg::OP_WRITE_STATUS_REGISTER ||
						link.rx_byte == fpc_pkg::OP_WRFR ||
						link.rx_byte == fpc_pkg::OP_SRP)
						state_q <= ST_DATA;
					else if (link.rx_byte == fpc_pkg::OP_PP ||
						link.rx_byte == fpc_pkg::OP_PPQ_A ||
						link.rx_byte == fpc_pkg::OP_PPQ_B ||
						link.rx_byte == fpc_pkg::OP_SE_A ||
						link.rx_byte == fpc_pkg::OP_SE_B ||
						link.rx_byte == fpc_pkg::OP_BE32 ||
						link.rx_byte == fpc_pkg::OP_BE64)
						state_q <= ST_ADDR;
					else
						state_q <= ST_DONE;
				end
				ST_ADDR: begin
					addr_q     <= {addr_q[ADDR_W-9:0], link.rx_byte};
					addr_cnt_q <= addr_cnt_q + 2'h1;
					if (addr_cnt_q == fpc_pkg::ADDR_BYTES - 2'h1)
						state_q <= ST_DONE;
				end
				ST_DATA: begin
					data_q      <= link.rx_byte;
					have_data_q <= 1'b1;
					state_q     <= ST_DONE;
				end
				ST_DONE: begin
					// Extra bytes such as page data are passed by
				end
			endcase
		end
	end

	// Register reads keep the same byte loaded for the whole frame
	always_comb begin
		link.tx_en   = 1'b0;
		link.tx_byte = 8'h00;
		if (state_q != ST_CMD) begin
			unique case (op_q)
				fpc_pkg::OP_RDSR: begin
					link.tx_en   = 1'b1;
					link.tx_byte = status;
				end
				fpc_pkg::OP_RDFR: begin
					link.tx_en   = 1'b1;
					link.tx_byte = fr_q;
				end
				fpc_pkg::OP_RDRP: begin
					link.tx_en   = 1'b1;
					link.tx_byte = rp_q;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Status register and write latch
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sr_q <= fpc_pkg::SR_RESET[7:2];
		end else if (write_ok && op_q == fpc_pkg::OP_WRITE_STATUS_REGISTER &&
			have_data_q && sr_unlocked) begin
			sr_q <= data_q[7:2];
		end
	end

	// Clears come first so a write-enable in the same cycle still wins
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wel_q <= fpc_pkg::SR_RESET[fpc_pkg::SR_WEL_BIT];
		end else begin
			if (array_done_in) begin
				wel_q <= 1'b0;
			end
			if (write_ok && have_data_q &&
				(op_q == fpc_pkg::OP_WRFR ||
				(op_q == fpc_pkg::OP_WRITE_STATUS_REGISTER && sr_unlocked))) begin
				wel_q <= 1'b0;
			end
			if (link.frame_end && op_q == fpc_pkg::OP_WRDI) begin
				wel_q <= 1'b0;
			end
			if (link.frame_end && op_q == fpc_pkg::OP_WRITE_ENABLE_CMD) begin
				wel_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// Function register
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fr_q <= fpc_pkg::FR_RESET;
		end else begin
			if (write_ok && op_q == fpc_pkg::OP_WRFR && have_data_q) begin
				// One-time bits can only be OR-ed in
				fr_q <= fr_q | (data_q & fpc_pkg::FR_OTP_MASK);
			end
			if (resume_in) begin
				fr_q[fpc_pkg::FR_PROGRAM_SUSPENDED_BIT] <= 1'b0;
				fr_q[fpc_pkg::FR_ERASE_SUSPENDED_BIT] <= 1'b0;
			end
			if (suspend_in && prog_active_in) begin
				fr_q[fpc_pkg::FR_PROGRAM_SUSPENDED_BIT] <= 1'b1;
			end
			if (suspend_in && erase_active_in) begin
				fr_q[fpc_pkg::FR_ERASE_SUSPENDED_BIT] <= 1'b1;
			end
		end
	end

	assign info_row_lock_out = fr_q[fpc_pkg::FR_IRL_LSB +: 4];

	// ****************************************
	// Read parameters and read helpers
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rp_q <= fpc_pkg::RP_RESET;
		end else if (link.frame_end && op_q == fpc_pkg::OP_SRP &&
			have_data_q) begin
			rp_q <= data_q;
		end
	end

	assign wrap_mask = ADDR_W'((7'h08 << rp_q[1:0]) - 7'h01);
	assign addr_inc = rd_addr_in + ADDR_W'(1);

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dummy_cycles_out   <= 4'h0;
			drive_strength_out <= fpc_pkg::RP_RESET[7:5];
			wrap_enable_out    <= 1'b0;
			burst_bytes_out    <= 7'h08;
			rd_next_addr_out   <= '0;
		end else begin
			dummy_cycles_out <= fpc_pkg::dummy_count(read_opcode_in,
				quad_command_mode_in,
				rp_q[fpc_pkg::RP_DUMMY_LSB +: 2]);
			drive_strength_out <= rp_q[fpc_pkg::RP_DRIVE_LSB +: 3];
			wrap_enable_out    <= rp_q[fpc_pkg::RP_WRAP_BIT];
			burst_bytes_out    <= 7'h08 << rp_q[1:0];
			if (rp_q[fpc_pkg::RP_WRAP_BIT]) begin
				rd_next_addr_out <= (rd_addr_in & ~wrap_mask) |
					(addr_inc & wrap_mask);
			end else begin
				rd_next_addr_out <= addr_inc;
			end
		end
	end

	// ****************************************
	// Program and erase admission
	// ****************************************
	assign is_chip_erase = op_q == fpc_pkg::OP_CE_A ||
		op_q == fpc_pkg::OP_CE_B;
	assign is_array_op = (state_q == ST_DONE && addr_cnt_q ==
		fpc_pkg::ADDR_BYTES) || is_chip_erase;
	assign blk_hit = fpc_pkg::blk_protected(lvl, fr_q[fpc_pkg::FR_TBS_BIT],
		addr_q[fpc_pkg::BLK_LSB +: 7]);

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			array_start_out   <= 1'b0;
			array_inhibit_out <= 1'b0;
			array_opcode_out  <= 8'h00;
			array_addr_out    <= '0;
		end else begin
			array_start_out   <= 1'b0;
			array_inhibit_out <= 1'b0;
			if (write_ok && is_array_op) begin
				array_opcode_out <= op_q;
				array_addr_out   <= addr_q;
				if (is_chip_erase ? (lvl != 4'h0) : blk_hit) begin
					array_inhibit_out <= 1'b1;
				end else begin
					array_start_out <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_LOCKED_SR_HOLDS: assert property (
		link.frame_end && op_q == fpc_pkg::OP_WRITE_STATUS_REGISTER && !sr_unlocked
		|=> $stable(sr_q))
		else $error("status bits changed while locked");
	AST_OTP_STICKY: assert property (
		(($past(fr_q) & fpc_pkg::FR_OTP_MASK) & ~fr_q) == 8'h00)
		else $error("one-time bit returned to zero");
	AST_CHIP_ERASE_GATED: assert property (
		array_start_out && (array_opcode_out == fpc_pkg::OP_CE_A ||
		array_opcode_out == fpc_pkg::OP_CE_B) |-> lvl == 4'h0)
		else $error("chip erase started with protection set");
	AST_NO_PROTECTED_START: assert property (
		array_start_out && !(array_opcode_out == fpc_pkg::OP_CE_A ||
		array_opcode_out == fpc_pkg::OP_CE_B) |-> !fpc_pkg::blk_protected(
		lvl, fr_q[fpc_pkg::FR_TBS_BIT], array_addr_out[22:16]))
		else $error("protected block was started");
	AST_ALL_PROTECTED: assert property (
		write_ok && is_array_op && lvl[3] |=> array_inhibit_out)
		else $error("operation passed with full protection");
	AST_SRP_LOAD: assert property (
		link.frame_end && op_q == fpc_pkg::OP_SRP && have_data_q
		|=> rp_q == $past(data_q) ##1 drive_strength_out == rp_q[7:5])
		else $error("read parameters not applied");
	AST_SPI_DUMMY_EIGHT: assert property (
		!quad_command_mode_in && read_opcode_in == fpc_pkg::OP_FRDO
		|=> dummy_cycles_out == 4'h8)
		else $error("dual output read dummy count wrong");
	AST_PROGRAM_SUSPENDED_SET: assert property (
		suspend_in && prog_active_in |=> fr_q[fpc_pkg::FR_PROGRAM_SUSPENDED_BIT])
		else $error("program suspend flag not set");
	// The window is the one in force when the address was computed
	AST_WRAP_BOUNDARY: assert property (
		rp_q[fpc_pkg::RP_WRAP_BIT] |=>
		(rd_next_addr_out & ~$past(wrap_mask)) ==
		($past(rd_addr_in) & ~$past(wrap_mask)))
		else $error("wrapped read left its burst window");
endmodule : fpc_regs_top

// [fpc_pkg.sv]
// Constants, opcodes and decode functions of the flash protect block
package fpc_pkg;
	// Instruction opcodes
	localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_RDSR   = 8'h05;
	localparam logic [7:0] OP_WRITE_STATUS_REGISTER   = 8'h01;
	localparam logic [7:0] OP_RDFR   = 8'h48;
	localparam logic [7:0] OP_WRFR   = 8'h42;
	localparam logic [7:0] OP_SRP    = 8'hC0;
	localparam logic [7:0] OP_RDRP   = 8'h61;
	localparam logic [7:0] OP_PP     = 8'h02;
	localparam logic [7:0] OP_PPQ_A  = 8'h32;
	localparam logic [7:0] OP_PPQ_B  = 8'h38;
	localparam logic [7:0] OP_SE_A   = 8'hD7;
	localparam logic [7:0] OP_SE_B   = 8'h20;
	localparam logic [7:0] OP_BE32   = 8'h52;
	localparam logic [7:0] OP_BE64   = 8'hD8;
	localparam logic [7:0] OP_CE_A   = 8'hC7;
	localparam logic [7:0] OP_CE_B   = 8'h60;
	localparam logic [7:0] OP_FRD    = 8'h0B;
	localparam logic [7:0] OP_FRDTR  = 8'h0D;
	localparam logic [7:0] OP_FRDO   = 8'h3B;
	localparam logic [7:0] OP_FRQO   = 8'h6B;
	localparam logic [7:0] OP_FRDIO  = 8'hBB;
	localparam logic [7:0] OP_FRDDTR = 8'hBD;
	localparam logic [7:0] OP_FRQIO  = 8'hEB;
	localparam logic [7:0] OP_FRQDTR = 8'hED;
	// Status register layout
	localparam int SR_LOCK_BIT = 7;
	localparam int SR_QE_BIT   = 6;
	localparam int SR_LVL_LSB  = 2;
	localparam int SR_WEL_BIT  = 1;
	localparam int SR_BUSY_BIT = 0;
	// Function register layout
	localparam int FR_TBS_BIT  = 1;
	localparam int FR_PROGRAM_SUSPENDED_BIT = 2;
	localparam int FR_ERASE_SUSPENDED_BIT = 3;
	localparam int FR_IRL_LSB  = 4;
	localparam logic [7:0] FR_OTP_MASK = 8'hF2;
	// Read parameter layout
	localparam int RP_DRIVE_LSB = 5;
	localparam int RP_DUMMY_LSB = 3;
	localparam int RP_WRAP_BIT  = 2;
	// Reset values
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [7:0] FR_RESET = 8'h00;
	localparam logic [7:0] RP_RESET = 8'hE0;
	// 64 KB block index lives in address bits 22:16
	localparam int BLK_LSB = 16;
	localparam logic [7:0] NUM_BLOCKS = 8'h80;
	localparam logic [1:0] ADDR_BYTES = 2'h3;

	// Protection of one block for a protect level and top/bottom choice
	function automatic logic blk_protected(input logic [3:0] lvl,
			input logic bottom, input logic [6:0] blk);
		logic [7:0] span;
		span = 8'h01 << (lvl[2:0] - 3'h1);
		if (lvl[3])
			return 1'b1;
		if (lvl[2:0] == 3'h0)
			return 1'b0;
		if (bottom)
			return {1'b0, blk} < span;
		return {1'b0, blk} >= (NUM_BLOCKS - span);
	endfunction : blk_protected

	// Dummy cycles per read opcode, mode-bit cycles included
	function automatic logic [3:0] dummy_count(input logic [7:0] op,
			input logic quad_command_mode, input logic [1:0] dsel);
		logic [3:0] quad_n;
		logic [3:0] dtr_n;
		logic [3:0] n;
		quad_n = (dsel == 2'h0) ? 4'h6 : (dsel == 2'h1) ? 4'h4 :
			(dsel == 2'h2) ? 4'h8 : 4'hA;
		dtr_n = (dsel == 2'h0) ? 4'h3 : (dsel == 2'h1) ? 4'h2 :
			(dsel == 2'h2) ? 4'h4 : 4'h5;
		case (op)
			OP_FRD:    n = quad_command_mode ? quad_n : 4'h8;
			OP_FRQIO:  n = quad_n;
			OP_FRDTR:  n = quad_command_mode ? dtr_n : 4'h4;
			OP_FRQDTR: n = dtr_n;
			OP_FRDIO:  n = dsel[1] ? 4'h8 : 4'h4;
			OP_FRDDTR: n = dsel[1] ? 4'h4 : 4'h2;
			OP_FRDO:   n = 4'h8;
			OP_FRQO:   n = 4'h8;
			default:   n = 4'h0;
		endcase
		return n;
	endfunction : dummy_count
endpackage : fpc_pkg

// [fpc_link_if.sv]
// Byte-level link between the serial shifter and the register logic
`timescale 1ns/1ps
interface fpc_link_if;
	logic       frame_start;
	logic       frame_end;
	logic       byte_valid;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	logic       tx_en;

	modport shifter (output frame_start, frame_end, byte_valid, rx_byte,
		input tx_byte, tx_en);
	modport regs (input frame_start, frame_end, byte_valid, rx_byte,
		output tx_byte, tx_en);
endinterface : fpc_link_if

// [fpc_spi_link.sv]
// Oversampling serial shifter: syncs the pins, finds clock edges, moves bytes
`timescale 1ns/1ps
module fpc_spi_link (
	input  wire logic sys_clk_in,
	input  wire logic rst_n_in,
	input  wire logic sck_in,
	input  wire logic ce_n_in,
	input  wire logic si_in,
	output logic      so_out,
	output logic      so_oe_out,
	fpc_link_if.shifter link
);
	logic [1:0] sck_s_q;
	logic [1:0] ce_s_q;
	logic [1:0] si_s_q;
	logic       sck_prev_q;
	logic       ce_prev_q;
	logic [2:0] bit_cnt_q;
	logic [6:0] rx_q;
	logic [7:0] tx_q;
	logic       active;
	logic       rise;
	logic       fall;

	// ****************************************
	// Synchronisers and edge detection
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sck_s_q    <= 2'h0;
			ce_s_q     <= 2'h3;
			si_s_q     <= 2'h0;
			sck_prev_q <= 1'b0;
			ce_prev_q  <= 1'b1;
		end else begin
			sck_s_q    <= {sck_s_q[0], sck_in};
			ce_s_q     <= {ce_s_q[0], ce_n_in};
			si_s_q     <= {si_s_q[0], si_in};
			sck_prev_q <= sck_s_q[1];
			ce_prev_q  <= ce_s_q[1];
		end
	end

	assign active = ~ce_s_q[1];
	assign rise   = active & sck_s_q[1] & ~sck_prev_q;
	assign fall   = active & ~sck_s_q[1] & sck_prev_q;

	// ****************************************
	// Receive side
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bit_cnt_q        <= 3'h0;
			rx_q             <= 7'h00;
			link.rx_byte     <= 8'h00;
			link.byte_valid  <= 1'b0;
			link.frame_start <= 1'b0;
			link.frame_end   <= 1'b0;
		end else begin
			link.byte_valid  <= 1'b0;
			link.frame_start <= ce_prev_q & ~ce_s_q[1];
			link.frame_end   <= ~ce_prev_q & ce_s_q[1];
			if (!active) begin
				bit_cnt_q <= 3'h0;
			end else if (rise) begin
				rx_q      <= {rx_q[5:0], si_s_q[1]};
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (bit_cnt_q == 3'h7) begin
					link.rx_byte    <= {rx_q, si_s_q[1]};
					link.byte_valid <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Transmit side, changes on falling clock
	// ****************************************
	// The byte is reloaded at every byte boundary, so a held-open
	// register read streams the same value again and again.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_q      <= 8'h00;
			so_out    <= 1'b0;
			so_oe_out <= 1'b0;
		end else begin
			so_oe_out <= active & link.tx_en;
			if (fall) begin
				if (bit_cnt_q == 3'h0) begin
					so_out <= link.tx_byte[7];
					tx_q   <= {link.tx_byte[6:0], 1'b0};
				end else begin
					so_out <= tx_q[7];
					tx_q   <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end
endmodule : fpc_spi_link

// [fpc_host_model.sv]
// Behavioural SPI host that frames commands towards the flash registers
`timescale 1ns/1ps
module fpc_host_model (
	input  wire logic clk_in,
	input  wire logic so_in,
	output logic      sck_out,
	output logic      ce_n_out,
	output logic      si_out
);
	// ********
	// Framing
	// ********
	initial begin
		{sck_out, ce_n_out, si_out} = 3'h2;
	end
	// Clock stands still between frames; a released data line toggles
	task automatic frame(input logic [7:0] q[$], input int nrd,
			output logic [15:0] rd);
		@(posedge clk_in);
		#1 ce_n_out = 1'b0;
		foreach (q[i])
			for (int b = 7; b >= 0; b--)
				bit_x(q[i][b], rd);
		repeat (nrd * 8)
			bit_x(~si_out, rd);
		#16 ce_n_out = 1'b1;
		si_out = ~si_out;
		#60;
	endtask : frame
	// Sample just before the fall, since read data only moves after a fall;
	// kept mid-cycle so it never lands on a system clock edge
	task automatic bit_x(input logic d, inout logic [15:0] rd);
		si_out = d;
		#16 sck_out = 1'b1;
		#14 rd = {rd[14:0], so_in};
		#2 sck_out = 1'b0;
	endtask : bit_x
endmodule : fpc_host_model

// [tb_fpc_regs_top.sv]
// Self-checking bench of the flash protect and read-config registers
`timescale 1ns/1ps
module tb_fpc_regs_top;
	logic        clk, rst_n, sck, ce_n, si, so, so_oe, wp, hold, quad_command_mode;
	logic        busy, done, sus, res, pact, eact, hact, dmode, wrap;
	logic        st, inh;
	logic [6:0]  bb, bk;
	logic [7:0]  rop, aop, v;
	logic [23:0] radr, nadr, aadr, a, m;
	logic [3:0]  dcy, irl, lv;
	logic [2:0]  drv;
	logic [15:0] rd;
	logic [31:0] r;
	logic [33:0] e;
	logic [33:0] exq[$];
	logic [31:0] seed = 32'h0000_001A;
	logic [7:0]  aops[7] = '{8'h02, 8'h32, 8'h38, 8'h20, 8'hD7, 8'h52,
		8'hD8};
	logic [7:0]  dops[10] = '{8'h03, 8'h0B, 8'h0D, 8'h3B, 8'h6B, 8'hBB,
		8'hBD, 8'hEB, 8'hED, 8'h05};
	int          err_count = 0;
	int          tests_run = 0;
	int          n;

	fpc_regs_top dut (
		.sys_clk_in(clk), .rst_n_in(rst_n), .sck_in(sck), .ce_n_in(ce_n),
		.io0_in(si), .io1_out(so), .io1_oe_out(so_oe), .io2_in(wp),
		.io3_in(hold), .quad_command_mode_in(quad_command_mode), .busy_in(busy),
		.array_done_in(done), .suspend_in(sus), .resume_in(res),
		.prog_active_in(pact), .erase_active_in(eact),
		.read_opcode_in(rop), .rd_addr_in(radr), .hold_active_out(hact),
		.io23_data_mode_out(dmode), .dummy_cycles_out(dcy),
		.drive_strength_out(drv), .wrap_enable_out(wrap),
		.burst_bytes_out(bb), .rd_next_addr_out(nadr),
		.array_start_out(st), .array_inhibit_out(inh),
		.array_opcode_out(aop), .array_addr_out(aadr),
		.info_row_lock_out(irl)
	);
	// A released data line reads back inverted, so undriven reads fail
	fpc_host_model host (.clk_in(clk), .so_in(so_oe ? so : ~so),
		.sck_out(sck), .ce_n_out(ce_n), .si_out(si));

	always #2 clk = ~clk;

	// ********
	// Checking
	// ********
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [3:0] dexp(input logic [7:0] o,
			input logic q, input logic [1:0] d);
		logic [3:0] qd, dt;
		qd = d[1] ? (d[0] ? 4'hA : 4'h8) : (d[0] ? 4'h4 : 4'h6);
		dt = d[1] ? (d[0] ? 4'h5 : 4'h4) : (d[0] ? 4'h2 : 4'h3);
		case (o)
			8'h0B: return q ? qd : 4'h8;
			8'hEB: return qd;
			8'h0D: return q ? dt : 4'h4;
			8'hED: return dt;
			8'hBB: return d[1] ? 4'h8 : 4'h4;
			8'hBD: return d[1] ? 4'h4 : 4'h2;
			8'h3B, 8'h6B: return 4'h8;
			default: return 4'h0;
		endcase
	endfunction : dexp
	function automatic logic prot(input logic bot, input logic [6:0] b);
		return lv[3] || (bot ? b < n : b >= 128 - n);
	endfunction : prot
	task automatic chk(input logic [33:0] g, input logic [33:0] x);
		tests_run++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic end_of_test;
		if (err_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// Chip erase carries no address, so only flag and opcode are compared
	always @(posedge clk) begin
		if ((st | inh) === 1'b1) begin
			e = exq.pop_front();
			chk({e[33], inh, aop, e[33] ? aadr : 24'h00_0000}, e);
		end
	end

	// ********
	// Stimulus
	// ********
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic rdreg(input logic [7:0] op, input logic [7:0] x);
		host.frame('{op}, 2, rd);
		chk(rd[15:8], x);
		chk(rd[7:0], x);
	endtask : rdreg
	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		host.frame('{8'h06}, 0, rd);
		host.frame('{op, d}, 0, rd);
	endtask : wr
	task automatic arr(input logic [7:0] op, input logic [23:0] ad,
			input logic ck, input logic x);
		exq.push_back({ck, x, op, ck ? ad : 24'h00_0000});
		host.frame('{8'h06}, 0, rd);
		if (ck)
			host.frame('{op, ad[23:16], ad[15:8], ad[7:0]}, 0, rd);
		else
			host.frame('{op}, 0, rd);
		tick;
		done = 1'b1;
		tick;
		done = 1'b0;
	endtask : arr

	initial begin
		{clk, rst_n, wp, hold} = 4'h3;
		{quad_command_mode, busy, done, sus, res, pact, eact} = 7'h00;
		{rop, radr} = 32'h0000_0000;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) tick;
		chk({so_oe, drv, bb}, {1'b0, 3'h7, 7'h08});
		rdreg(8'h05, 8'h00);
		rdreg(8'h48, 8'h00);
		rdreg(8'h61, 8'hE0);
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			v = {r[7:3], k[0], k[1:0]};
			host.frame('{8'hC0, v}, 0, rd);
			a = r[31:8] | 24'h00_003F;
			m = (24'h00_0008 << k) - 24'h00_0001;
			tick;
			radr = a;
			tick;
			chk({drv, wrap, bb}, {v[7:5], v[2], 7'h08 << k});
			chk(nadr, v[2] ? a & ~m : a + 24'h00_0001);
			rdreg(8'h61, v);
		end
		for (int d = 0; d < 4; d++) begin
			r = rnd();
			host.frame('{8'hC0, {r[7:5], d[1:0], r[2:0]}}, 0, rd);
			for (int i = 0; i < 20; i++) begin
				tick;
				rop = dops[i % 10];
				quad_command_mode = (i >= 10);
				tick;
				chk(dcy, dexp(rop, quad_command_mode, d[1:0]));
			end
		end
		for (int t = 0; t < 2; t++) begin
			for (int l = 0; l < 9; l++) begin
				r = rnd();
				lv = (l == 8) ? {1'b1, r[2:0]} : l[3:0];
				n = (lv[2:0] == 3'h0) ? 0 : 1 << (lv[2:0] - 3'h1);
				wr(8'h01, {2'h0, lv, 2'h0});
				arr(l[0] ? 8'hC7 : 8'h60, 24'h00_0000, 1'b0, lv != 0);
				for (int j = 0; j < 4; j++) begin
					bk = 7'(j[1] ? 127 - n + j[0] : n - 1 + j[0]);
					arr(aops[(l * 4 + j) % 7], {1'b0, bk, r[15:0]}, 1'b1,
						prot(t[0], bk));
				end
			end
			wr(8'h42, 8'h02);
		end
		wr(8'h42, 8'h00);
		rdreg(8'h48, 8'h02);
		wr(8'h42, 8'hFD);
		rdreg(8'h48, 8'hF2);
		chk(irl, 4'hF);
		for (int s = 0; s < 2; s++) begin
			tick;
			{pact, eact, sus} = {~s[0], s[0], 1'b1};
			tick;
			sus = 1'b0;
			rdreg(8'h48, 8'hF2 | (8'h04 << s));
			tick;
			res = 1'b1;
			tick;
			{res, pact, eact} = 3'h0;
			rdreg(8'h48, 8'hF2);
		end
		wr(8'h01, 8'h84);
		tick;
		wp = 1'b0;
		wr(8'h01, 8'h00);
		rdreg(8'h05, 8'h86);
		tick;
		wp = 1'b1;
		wr(8'h01, 8'h40);
		rdreg(8'h05, 8'h40);
		for (int q = 0; q < 2; q++) begin
			tick;
			hold = 1'b0;
			repeat (4) tick;
			chk({dmode, hact}, {~q[0], q[0]});
			hold = 1'b1;
			wr(8'h01, 8'h00);
		end
		// A busy array refuses the status write but shows in bit 0
		busy = 1'b1;
		wr(8'h01, 8'h40);
		rdreg(8'h05, 8'h03);
		busy = 1'b0;
		host.frame('{8'h04}, 0, rd);
		rdreg(8'h05, 8'h00);
		chk(34'(exq.size()), 34'h0);
		end_of_test;
	end
	initial begin
		#300_000;
		err_count++;
		end_of_test;
	end
endmodule : tb_fpc_regs_top
